// File: src/closed_loop_margin_pwm.sv
// What this block does
// R01: pwm output repeats at 62.5 khz.
// R02: duty is a 6-bit value, 64 settings.
// R03: margining only while operation selects margin high or low.
// R04: margining waits until all enabled channels are power good.
// R05: on start enable pwm and load the seed duty.
// R06: average eight samples over 40 ms; at most one change per period.
// R07: step duty by one when average misses target by over target/128.
// R08: step direction follows the slope bit toward the target.
// R09: slope 0 means higher duty lowers voltage; 1 raises it.
// R10: duty at 0% or 100% with target unmet is a failure; keep trying.
// R11: failure sets status byte, word and vendor-specific bits.
// R12: failure raises alert only when enabled in vendor mode control.
// R13: first average at seed compared; seed overshoot is a failure.
// R14: after overshoot keep regulating with the same failure actions.
// R15: config bits 14:6 read as zero.
// R16: config bits 5:0 hold the seed for both directions.
// R17: one step is one lsb; duty saturates, never wraps.
`include "margin_pwm_map.svh"
module closed_loop_margin_pwm
  import margin_pwm_pkg::*;
#(
  parameter int DUTY_W = 6,
  parameter int VW = 16,
  parameter int AVG_CYC = `AVG_PERIOD_CYC,
  parameter int SAMPLE_CYC = `SAMPLE_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  output logic [15:0] o_cfg_rdata,
  input wire logic [1:0] i_operation,
  input wire logic i_all_power_good,
  input wire logic i_alert_enable,
  input wire logic [VW-1:0] i_vout,
  input wire logic [VW-1:0] i_vout_margin_high,
  input wire logic [VW-1:0] i_vout_margin_low,
  input wire logic i_status_clear,
  output logic o_pwm,
  output logic o_pwm_enable,
  output logic [DUTY_W-1:0] o_duty,
  output logic o_status_byte_nota,
  output logic o_status_word_nota,
  output logic o_status_word_mfr,
  output logic o_status_mfr_margin_fault,
  output logic o_alert
);
  localparam int SW = VW + 3;
  localparam int CW = $clog2(SAMPLE_CYC + 1);
  localparam logic [DUTY_W-1:0] DMAX = {DUTY_W{1'b1}};

  // refused at elaboration: widths and periods the loop cannot serve
  if (DUTY_W != 6 || SAMPLE_CYC < 1 || AVG_CYC != SAMPLE_CYC * 8)
  begin : g_param_check
    $error("unsupported margin parameters");
  end

  function automatic logic margin_mode(input logic [1:0] op);
    margin_mode = (op == op_margin_low) || (op == op_margin_high);
  endfunction

  // configuration register
  logic slope;
  logic [DUTY_W-1:0] seed;
  logic next_slope;
  logic [DUTY_W-1:0] next_seed;
  logic [15:0] next_rdata;

  always_comb
  begin
    next_slope = slope;
    next_seed = seed;
    if (i_cmd_wr && i_cmd_code == `CFG_OFFSET)
    begin
      next_slope = i_cmd_wdata[`CFG_SLOPE_BIT];
      next_seed = i_cmd_wdata[`CFG_SEED_MSB:`CFG_SEED_LSB]; // R16
    end
    next_rdata = {next_slope, 9'h000, next_seed}; // R15
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      slope <= 1'(`CFG_RESET >> `CFG_SLOPE_BIT);
      seed <= DUTY_W'(`CFG_RESET >> `CFG_SEED_LSB);
      o_cfg_rdata <= `CFG_RESET;
    end
    else
    begin
      slope <= next_slope;
      seed <= next_seed;
      o_cfg_rdata <= next_rdata;
    end
  end

  // margin loop
  margin_state_type state;
  margin_state_type next_state;
  logic [CW-1:0] cyc;
  logic [CW-1:0] next_cyc;
  logic [2:0] nsamp;
  logic [2:0] next_nsamp;
  logic [SW-1:0] acc;
  logic [SW-1:0] next_acc;
  logic [DUTY_W-1:0] next_duty;
  logic next_en;
  logic fail;
  logic [VW-1:0] avg;
  logic [VW-1:0] target;
  logic [VW:0] tol;
  logic high;
  logic low;
  logic overshoot;
  logic up;
  logic active;

  always_comb
  begin
    next_state = state;
    next_cyc = cyc;
    next_nsamp = nsamp;
    next_acc = acc;
    next_duty = o_duty;
    next_en = o_pwm_enable;
    fail = 1'b0;
    avg = '0;
    high = 1'b0;
    low = 1'b0;
    overshoot = 1'b0;
    up = 1'b0;
    target = (i_operation == op_margin_high) ?
      i_vout_margin_high : i_vout_margin_low;
    tol = (VW + 1)'(target >> `TOL_SHIFT);
    active = margin_mode(i_operation); // R03
    if (!active)
    begin
      next_state = st_idle;
      next_en = 1'b0;
    end
    else
    begin
      case (state)
        st_idle:
        begin
          if (i_all_power_good) // R04
          begin
            next_state = st_seed;
            next_en = 1'b1; // R05
            next_duty = seed; // R05 R16
            next_cyc = '0;
            next_nsamp = '0;
            next_acc = '0;
          end
        end
        st_seed, st_run:
        begin
          next_cyc = cyc + 1'b1;
          if (cyc == CW'(SAMPLE_CYC - 1))
          begin
            next_cyc = '0;
            next_acc = acc + SW'(i_vout); // R06
            next_nsamp = nsamp + 1'b1;
            if (nsamp == 3'h7)
            begin
              next_acc = '0;
              avg = VW'((acc + SW'(i_vout)) >> 3); // R06
              high = {1'b0, avg} > ({1'b0, target} + tol); // R07
              low = ({1'b0, avg} + tol) < {1'b0, target}; // R07
              up = (low == slope); // R08 R09
              overshoot = (i_operation == op_margin_high) ? high : low;
              if (state == st_seed && overshoot)
              begin
                fail = 1'b1; // R13
              end
              next_state = st_run; // R14
              if (high || low)
              begin
                if (up && o_duty != DMAX)
                begin
                  next_duty = o_duty + 1'b1; // R07 R17
                end
                else if (!up && o_duty != '0)
                begin
                  next_duty = o_duty - 1'b1; // R07 R17
                end
                else
                begin
                  fail = 1'b1; // R10
                end
              end
            end
          end
        end
        default:
        begin
          next_state = st_idle;
        end
      endcase
    end
  end

  // sticky status, set wins over clear
  logic next_flag;
  logic next_alert;

  always_comb
  begin
    next_flag = fail || (o_status_mfr_margin_fault && !i_status_clear); // R11
    next_alert = (fail && i_alert_enable) || (o_alert && !i_status_clear); // R12
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      state <= st_idle;
      cyc <= '0;
      nsamp <= '0;
      acc <= '0;
      o_duty <= '0;
      o_pwm_enable <= 1'b0;
      o_status_byte_nota <= 1'b0;
      o_status_word_nota <= 1'b0;
      o_status_word_mfr <= 1'b0;
      o_status_mfr_margin_fault <= 1'b0;
      o_alert <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cyc <= next_cyc;
      nsamp <= next_nsamp;
      acc <= next_acc;
      o_duty <= next_duty;
      o_pwm_enable <= next_en;
      o_status_byte_nota <= next_flag; // R11
      o_status_word_nota <= next_flag; // R11
      o_status_word_mfr <= next_flag; // R11
      o_status_mfr_margin_fault <= next_flag; // R11
      o_alert <= next_alert; // R12
    end
  end

  pwm_out #(
    .PERIOD(`PWM_PERIOD_CYC),
    .DUTY_W(DUTY_W)
  ) u_pwm (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_enable(o_pwm_enable),
    .i_duty(o_duty), // R02
    .o_pwm(o_pwm)
  );
endmodule

// File: src/margin_pwm_map.svh
`ifndef MARGIN_PWM_MAP_SVH
`define MARGIN_PWM_MAP_SVH

`define CFG_OFFSET 8'he0
`define CFG_SLOPE_BIT 15
`define CFG_SEED_MSB 5
`define CFG_SEED_LSB 0
`define CFG_RESET 16'h0000
`define CLK_HZ 250000000
`define PWM_HZ 62500
`define PWM_PERIOD_CYC (`CLK_HZ / `PWM_HZ)
`define AVG_TIME_MS 40
`define AVG_SAMPLES 8
`define AVG_PERIOD_CYC ((`CLK_HZ / 1000) * `AVG_TIME_MS)
`define SAMPLE_CYC (`AVG_PERIOD_CYC / `AVG_SAMPLES)
`define TOL_SHIFT 7

`endif

// File: src/margin_pwm_pkg.sv
package margin_pwm_pkg;
  typedef enum logic [2:0]
  {
    st_idle = 3'b001,
    st_seed = 3'b010,
    st_run = 3'b100
  } margin_state_type;
  typedef enum logic [1:0]
  {
    op_off = 2'h0,
    op_normal = 2'h1,
    op_margin_low = 2'h2,
    op_margin_high = 2'h3
  } op_mode_type;
endpackage

// File: src/pwm_out.sv
// duty*(PERIOD/64, rounded down) cycles of each period high; duty 63 gives a full-high period
module pwm_out
  import margin_pwm_pkg::*;
#(
  parameter int PERIOD = 4000,
  parameter int DUTY_W = 6
)
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic [DUTY_W-1:0] i_duty,
  output logic o_pwm
);
  localparam int STEP = PERIOD / (1 << DUTY_W);
  localparam int CW = $clog2(PERIOD);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_pwm;
  logic [CW-1:0] thresh;

  // refused at elaboration: a period shorter than the duty range
  if (PERIOD < (1 << DUTY_W))
  begin : g_period_check
    $error("pwm period too short");
  end

  always_comb
  begin
    next_count = (count == CW'(PERIOD - 1)) ? '0 : count + 1'b1; // R01
    if (i_duty == {DUTY_W{1'b1}})
    begin
      thresh = CW'(PERIOD - 1);
      next_pwm = i_enable;
    end
    else
    begin
      thresh = CW'(STEP * int'(i_duty));
      next_pwm = i_enable && (next_count < thresh);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      count <= '0;
      o_pwm <= 1'b0;
    end
    else
    begin
      count <= next_count;
      o_pwm <= next_pwm;
    end
  end
endmodule

// File: verification/closed_loop_margin_pwm_asserts.sv
module closed_loop_margin_pwm_asserts
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic [15:0] o_cfg_rdata,
  input wire logic [1:0] i_operation,
  input wire logic i_all_power_good,
  input wire logic i_alert_enable,
  input wire logic o_pwm_enable,
  input wire logic [5:0] o_duty,
  input wire logic o_status_byte_nota,
  input wire logic o_status_word_nota,
  input wire logic o_status_word_mfr,
  input wire logic o_status_mfr_margin_fault,
  input wire logic o_alert
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  AST_CFG: assert property (i_cmd_wr && i_cmd_code == 8'he0 |=>
    o_cfg_rdata == {$past(i_cmd_wdata[15]), 9'h0, $past(i_cmd_wdata[5:0])})
    else $error("config readback wrong");
  AST_OFF: assert property (!i_operation[1] |=> !o_pwm_enable)
    else $error("pwm enabled outside margin mode");
  AST_PG: assert property ($rose(o_pwm_enable) |-> $past(i_all_power_good))
    else $error("margin started before power good");
  AST_SEED: assert property ($rose(o_pwm_enable) |->
    o_duty == o_cfg_rdata[5:0]) else $error("seed not loaded");
  AST_STEP: assert property (o_pwm_enable && $past(o_pwm_enable) &&
    o_duty != $past(o_duty) |-> o_duty == $past(o_duty) + 6'h1 ||
    o_duty == $past(o_duty) - 6'h1) else $error("duty step not one");
  AST_HOLD: assert property (o_pwm_enable && $changed(o_duty) ##1
    o_pwm_enable |-> $stable(o_duty)[*8]) else $error("duty changed early");
  AST_FLAGS: assert property ($rose(o_status_mfr_margin_fault) |->
    o_status_byte_nota && o_status_word_nota && o_status_word_mfr)
    else $error("status flags incomplete");
  AST_ALERT: assert property ($rose(o_alert) |-> $past(i_alert_enable) &&
    o_status_mfr_margin_fault) else $error("alert without cause");
  cover property ($rose(o_pwm_enable));
  cover property ($rose(o_status_mfr_margin_fault));
  cover property ($rose(o_alert));
endmodule

bind closed_loop_margin_pwm closed_loop_margin_pwm_asserts u_chk (.*);

// File: verification/supply_model.sv
module supply_model
(
  input wire logic i_en,
  input wire logic i_rise,
  input wire logic [5:0] i_duty,
  output logic [15:0] o_vout
);
  timeunit 1ns;
  timeprecision 1ps;
  // filtered trim moves vout 16 per duty count; nominal while pwm is off
  always_comb
    if (!i_en)
      o_vout = 16'h03e8;
    else if (i_rise)
      o_vout = {6'h0, i_duty, 4'h0};
    else
      o_vout = 16'h07d0 - {6'h0, i_duty, 4'h0};
endmodule

// File: verification/closed_loop_margin_pwm_tb.sv
module closed_loop_margin_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic [7:0] code = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] op = 2'h0;
  logic pg = 1'b0, aen = 1'b0, clr = 1'b0, rise = 1'b0, p1 = 1'b0, p2 = 1'b0;
  logic [15:0] hi = 16'h0200;
  logic [15:0] lo = 16'h01f4;
  logic [15:0] vout, rdata;
  logic pwm, en, nota_b, nota_w, mfr_w, fault, alert;
  logic [5:0] duty;
  logic [15:0] exp_cfg[$];
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_hi = 0;
  int n_per = 0;
  always #2 clk = ~clk;
  closed_loop_margin_pwm #(.SAMPLE_CYC(4), .AVG_CYC(32)) u_dut
  (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_cmd_wr(wr), .i_cmd_code(code),
    .i_cmd_wdata(wdata), .o_cfg_rdata(rdata), .i_operation(op),
    .i_all_power_good(pg), .i_alert_enable(aen), .i_vout(vout),
    .i_vout_margin_high(hi), .i_vout_margin_low(lo), .i_status_clear(clr),
    .o_pwm(pwm), .o_pwm_enable(en), .o_duty(duty),
    .o_status_byte_nota(nota_b), .o_status_word_nota(nota_w),
    .o_status_word_mfr(mfr_w), .o_status_mfr_margin_fault(fault),
    .o_alert(alert)
  );
  supply_model u_supply (.i_en(en), .i_rise(rise), .i_duty(duty), .o_vout(vout));
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic write(logic [7:0] c, logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    code = c;
    wdata = d;
    if (c == 8'he0)
      exp_cfg.push_back({d[15], 9'h0, d[5:0]});
    @(negedge clk);
    wr = 1'b0;
  endtask
  // one full pwm period sampled on falling edges, from a rising output
  task automatic pwm_period(output int high_n, output int per_n);
    high_n = 0;
    per_n = 0;
    @(negedge clk iff !pwm);
    @(negedge clk iff pwm);
    while (pwm)
    begin
      high_n++;
      per_n++;
      @(negedge clk);
    end
    while (!pwm)
    begin
      per_n++;
      @(negedge clk);
    end
  endtask
  task automatic margin(logic [1:0] m, logic r, logic [15:0] cfg, int n);
    write(8'he0, cfg);
    rise = r;
    op = m;
    repeat (n) @(negedge clk);
  endtask
  // readback lands on the same edge that takes the write
  always @(posedge clk)
  begin
    p1 <= wr && code == 8'he0;
    p2 <= p1;
  end
  always @(negedge clk)
    if (p2)
      chk("cfg", exp_cfg.pop_front(), rdata);
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      complete_run();
    end
  end
  initial
  begin
    void'($urandom(71016));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk("cfg0", 16'h0000, rdata);
    for (int i = 0; i < 6; i++)
      write(i[0] ? 8'he1 : 8'he0, 16'($urandom));
    margin(2'h3, 1'b1, 16'h800a, 100);
    chk("wait", 16'h0000, {15'h0, en});
    pg = 1'b1;
    repeat (2) @(negedge clk);
    chk("seed", 16'h000a, {10'h0, duty});
    repeat (900) @(negedge clk);
    chk("conv", 16'h0020, {10'h0, duty});
    chk("nofault", 16'h0000, {15'h0, fault});
    op = 2'h1;
    repeat (2) @(negedge clk);
    chk("off", 16'h0000, {15'h0, en});
    margin(2'h3, 1'b1, 16'h8028, 45);
    chk("over", 16'h000f, {12'h0, nota_b, nota_w, mfr_w, fault});
    chk("noalert", 16'h0000, {15'h0, alert});
    repeat (700) @(negedge clk);
    chk("regul", 16'h0020, {10'h0, duty});
    op = 2'h1;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    chk("clr", 16'h0000, {14'h0, fault, alert});
    aen = 1'b1;
    margin(2'h2, 1'b0, 16'h0002, 2300);
    chk("sat", 16'h003f, {10'h0, duty});
    chk("fail", 16'h001f, {11'h0, nota_b, nota_w, mfr_w, fault, alert});
    chk("pwm", 16'h0001, {15'h0, pwm});
    // leave margining so the next entry reloads the seed
    op = 2'h1;
    @(negedge clk);
    margin(2'h3, 1'b1, 16'h8020, 40);
    chk("keep", 16'h0020, {10'h0, duty});
    pwm_period(n_hi, n_per);
    chk("period", 16'h0fa0, 16'(n_per));
    chk("high", 16'h07c0, 16'(n_hi));
    // reset again in mid-run
    op = 2'h1;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("rst_cfg", 16'h0000, rdata);
    chk("rst_out", 16'h0000, {9'h0, en, duty, pwm});
    chk("rst_flag", 16'h0000, {11'h0, nota_b, nota_w, mfr_w, fault, alert});
    complete_run();
  end
endmodule
